// *** rtnf_pkg.sv ***
// Constants, state codes and preset curve shape for the recursive temporal noise filter.
// Assumes one 100 MHz datapath clock and 16-bit video words with luma in 7:0 and chroma in 15:8.
// Notes on behaviour
// - Motion is the absolute 3x5 box average of current minus previous difference.
// - Each pixel's motion value addresses the active recursion_curve to get its coefficient.
// - Output is current pixel plus coefficient times frame difference.
// - Filtered frame goes to memory and returns as previous frame next period.
// - Separate luma and chroma engines; chroma alternates its two components internally.
// - Eight presets in banks 0-7, strongest first; a parameter picks the power-up bank.
// - Curves cover motion 0..127; larger motion saturates to address 127.
// - Sixteen curve tables stored; one table active for a whole frame.
// - Each curve has 128 coefficients, separate for luma and chroma.
// - Active bank may change at each frame boundary; curve contents change on the cycle they are written.
// - An overwritten preset is gone until the device is reconfigured.
// - Per-frame noise and motion totals are computed and readable.
// - Video streams carry 8-bit luma in bits 7:0 and chroma in 15:8; the motion stream carries 7-bit luma and chroma motion in those lanes.
// - Two input stream slaves aligned by an internal FIFO and back-pressure.
// - Current-frame ready stays high; that source is never stalled.
// - Previous stream purges to start-of-frame, then stalls until current start-of-frame.
// - Line ends are resynchronised by the same discard-and-stall method.
// - Filtered video to memory, duplicated on a second output, motion on a third.
// - Masked, enabled events, including frame-begin when a new frame starts.
// - Status bits stick until written one; live event outputs do not hold.

package rtnf_pkg;

  localparam int          DATA_W       = 16;
  localparam int          PIX_W        = 8;
  localparam int          CHANNELS     = 2;
  localparam int          CURVE_DEPTH  = 128;
  localparam int          CURVE_BANKS  = 16;
  localparam int          PRESET_BANKS = 8;
  localparam int          LINE_MAX     = 2048;
  localparam int          COL_SR_LEN   = 8;
  localparam int          EVT_W        = 3;
  localparam int          EVT_STARTED  = 0;
  localparam int          EVT_SYNC     = 1;
  localparam int          EVT_UNDERRUN = 2;
  localparam logic [6:0]  MOTION_MAX   = 7'h7F;
  localparam logic [4:0]  FIR_SCALE    = 5'h11;
  localparam int          FIR_SHIFT    = 8;
  localparam int          COEF_SHIFT   = 8;
  localparam logic [7:0]  NOISE_THRESH = 8'h80;
  localparam logic [7:0]  PRESET_PEAK  = 8'hF0;
  localparam int          PRESET_KNEE  = 8;
  localparam int          PRESET_STEP  = 15;
  localparam logic [1:0]  FIFO_DEPTH   = 2'h2;

  typedef enum logic [2:0] {
    RTNF_PURGE_SOF = 3'b000,
    RTNF_WAIT_SOF  = 3'b001,
    RTNF_RUN       = 3'b010,
    RTNF_PURGE_EOL = 3'b011,
    RTNF_WAIT_EOL  = 3'b100
  } rtnf_sync_e;

  // Flat shelf then halving roll-off, attenuated by bank; last entry forced to zero.
  function automatic logic [7:0] rtnf_preset(input int bank, input int m);
    int base;
    base = (m < PRESET_KNEE) ? int'(PRESET_PEAK) : (int'(PRESET_PEAK) >> ((m - PRESET_KNEE) / PRESET_STEP));
    if (bank >= PRESET_BANKS || m == CURVE_DEPTH - 1)
      base = 0;
    else
      base = (base * (PRESET_BANKS - bank)) / PRESET_BANKS;
    return base[7:0];
  endfunction : rtnf_preset

endpackage : rtnf_pkg

// *** rtnf_filter.sv ***
// Recursive temporal noise filter: stream alignment, motion estimate, curve lookup and blend.
// Assumes the previous-frame stream can be stalled and all three outputs accept every beat.
`timescale 1ns/1ps
`default_nettype none

module rtnf_filter #(
  parameter int PRESET_BANK = 0
) (
  // Clock and reset
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST,
  // Current-frame stream slave
  input  wire logic [15:0]          S_CURR_TDATA,
  input  wire logic                 S_CURR_TVALID,
  input  wire logic                 S_CURR_TUSER,
  input  wire logic                 S_CURR_TLAST,
  output logic                      S_CURR_TREADY,
  // Previous-frame stream slave
  input  wire logic [15:0]          S_PREV_TDATA,
  input  wire logic                 S_PREV_TVALID,
  input  wire logic                 S_PREV_TUSER,
  input  wire logic                 S_PREV_TLAST,
  output logic                      S_PREV_TREADY,
  // Memory write-back stream
  output logic [15:0]               M_MEM_TDATA,
  output logic                      M_MEM_TVALID,
  output logic                      M_MEM_TUSER,
  output logic                      M_MEM_TLAST,
  // Duplicate video stream
  output logic [15:0]               M_OUT_TDATA,
  output logic                      M_OUT_TVALID,
  output logic                      M_OUT_TUSER,
  output logic                      M_OUT_TLAST,
  // Motion stream
  output logic [15:0]               M_MOTION_TDATA,
  output logic                      M_MOTION_TVALID,
  output logic                      M_MOTION_TUSER,
  output logic                      M_MOTION_TLAST,
  // Curve control
  input  wire logic [3:0]           BANK_SEL,
  input  wire logic                 CURVE_WE,
  input  wire logic                 CURVE_CHAN,
  input  wire logic [3:0]           CURVE_BANK,
  input  wire logic [6:0]           CURVE_ADDR,
  input  wire logic [7:0]           CURVE_DATA,
  // Frame statistics
  output logic [31:0]               FRAME_NOISE,
  output logic [31:0]               FRAME_MOTION,
  // Events
  output logic [2:0]                EVENT_LIVE,
  output logic [2:0]                EVENT_STATUS,
  input  wire logic [2:0]           EVENT_CLEAR,
  input  wire logic [2:0]           EVENT_ENABLE,
  output logic                      EVENT_IRQ
);

  // ********************************************************************
  // Previous-frame FIFO
  // ********************************************************************
  // Two entries let ready come from a flip-flop without ever dropping a beat.
  logic [15:0]      fifo_data [2];
  logic [1:0]       fifo_sof;
  logic [1:0]       fifo_eol;
  logic             wptr_reg, wptr_next;
  logic             rptr_reg, rptr_next;
  logic [1:0]       count_reg, count_next;
  logic             prev_rdy_reg, prev_rdy_next;
  logic             push;
  logic             pop;
  logic             head_v;
  logic             head_s;
  logic             head_e;

  assign push   = S_PREV_TVALID & prev_rdy_reg;
  assign head_v = (count_reg != 2'h0);
  assign head_s = fifo_sof[rptr_reg];
  assign head_e = fifo_eol[rptr_reg];

  always_comb
  begin
    wptr_next     = wptr_reg ^ push;
    rptr_next     = rptr_reg ^ pop;
    count_next    = count_reg + {1'b0, push} - {1'b0, pop};
    prev_rdy_next = (count_next < rtnf_pkg::FIFO_DEPTH);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (push)
    begin
      fifo_data[wptr_reg] <= S_PREV_TDATA;
      fifo_sof[wptr_reg]  <= S_PREV_TUSER;
      fifo_eol[wptr_reg]  <= S_PREV_TLAST;
    end
    if (RST)
    begin
      wptr_reg     <= 1'b0;
      rptr_reg     <= 1'b0;
      count_reg    <= 2'h0;
      prev_rdy_reg <= 1'b0;
    end
    else
    begin
      wptr_reg     <= wptr_next;
      rptr_reg     <= rptr_next;
      count_reg    <= count_next;
      prev_rdy_reg <= prev_rdy_next;
    end
  end

  // ********************************************************************
  // Stream alignment
  // ********************************************************************
  // Unpaired current beats pass with previous taken equal to current, i.e. unfiltered.
  rtnf_pkg::rtnf_sync_e state_reg, state_next;
  logic             use_prev;
  logic             started;
  logic             sync_err;
  logic             under;

  always_comb
  begin
    state_next = state_reg;
    pop        = 1'b0;
    use_prev   = 1'b0;
    started    = 1'b0;
    sync_err   = 1'b0;
    under      = 1'b0;
    case (state_reg)
      rtnf_pkg::RTNF_PURGE_SOF, rtnf_pkg::RTNF_WAIT_SOF:
      begin
        if (head_v && head_s)
        begin
          if (S_CURR_TVALID && S_CURR_TUSER)
          begin
            pop        = 1'b1;
            use_prev   = 1'b1;
            started    = 1'b1;
            state_next = rtnf_pkg::RTNF_RUN;
          end
          else
            state_next = rtnf_pkg::RTNF_WAIT_SOF;
        end
        else if (head_v)
          pop = 1'b1;
      end
      rtnf_pkg::RTNF_RUN:
      begin
        if (S_CURR_TVALID)
        begin
          if (!head_v)
            under = 1'b1;
          else if (S_CURR_TUSER != head_s)
          begin
            sync_err   = 1'b1;
            state_next = S_CURR_TUSER ? rtnf_pkg::RTNF_PURGE_SOF : rtnf_pkg::RTNF_WAIT_SOF;
          end
          else
          begin
            pop      = !(head_e && !S_CURR_TLAST);
            use_prev = pop;
            started  = S_CURR_TUSER;
            if (S_CURR_TLAST != head_e)
            begin
              sync_err   = 1'b1;
              state_next = S_CURR_TLAST ? rtnf_pkg::RTNF_PURGE_EOL : rtnf_pkg::RTNF_WAIT_EOL;
            end
          end
        end
      end
      rtnf_pkg::RTNF_PURGE_EOL:
      begin
        if (head_v)
        begin
          pop = 1'b1;
          if (head_e)
            state_next = rtnf_pkg::RTNF_RUN;
        end
      end
      rtnf_pkg::RTNF_WAIT_EOL:
      begin
        if (S_CURR_TVALID && S_CURR_TLAST && head_v)
        begin
          pop        = 1'b1;
          use_prev   = 1'b1;
          state_next = rtnf_pkg::RTNF_RUN;
        end
      end
      default:
        state_next = rtnf_pkg::RTNF_PURGE_SOF;
    endcase
  end

  // ********************************************************************
  // Input stage and line position
  // ********************************************************************
  logic             s1_v_reg, s1_v_next;
  logic             s1_s_reg, s1_s_next;
  logic             s1_e_reg, s1_e_next;
  logic [15:0]      s1_cur_reg, s1_cur_next;
  logic [15:0]      s1_prv_reg, s1_prv_next;
  logic [10:0]      x_reg, x_next;
  logic [10:0]      s1_x_reg, s1_x_next;

  always_comb
  begin
    s1_v_next   = S_CURR_TVALID;
    s1_s_next   = S_CURR_TUSER;
    s1_e_next   = S_CURR_TLAST;
    s1_cur_next = S_CURR_TDATA;
    s1_prv_next = use_prev ? fifo_data[rptr_reg] : S_CURR_TDATA;
    s1_x_next   = x_reg;
    x_next      = x_reg;
    if (S_CURR_TVALID)
    begin
      if (S_CURR_TLAST || S_CURR_TUSER)
        x_next = S_CURR_TLAST ? 11'h000 : 11'h001;
      else if (x_reg != 11'(rtnf_pkg::LINE_MAX - 1))
        x_next = x_reg + 11'h001;
      if (S_CURR_TUSER)
        s1_x_next = 11'h000;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_reg     <= rtnf_pkg::RTNF_PURGE_SOF;
      S_CURR_TREADY <= 1'b0;
      s1_v_reg      <= 1'b0;
      s1_s_reg      <= 1'b0;
      s1_e_reg      <= 1'b0;
      s1_cur_reg    <= 16'h0000;
      s1_prv_reg    <= 16'h0000;
      x_reg         <= 11'h000;
      s1_x_reg      <= 11'h000;
    end
    else
    begin
      state_reg     <= state_next;
      S_CURR_TREADY <= 1'b1;
      s1_v_reg      <= s1_v_next;
      s1_s_reg      <= s1_s_next;
      s1_e_reg      <= s1_e_next;
      s1_cur_reg    <= s1_cur_next;
      s1_prv_reg    <= s1_prv_next;
      x_reg         <= x_next;
      s1_x_reg      <= s1_x_next;
    end
  end

  assign S_PREV_TREADY = prev_rdy_reg;

  // ********************************************************************
  // Curve bank selection
  // ********************************************************************
  logic             s2_v_reg;
  logic             s2_s_reg;
  logic             s2_e_reg;
  logic [3:0]       bank_reg, bank_next;
  logic [3:0]       bank_use;

  assign bank_use = (s2_v_reg && s2_s_reg) ? BANK_SEL : bank_reg;

  always_comb
  begin
    bank_next = bank_use;
  end

  // ********************************************************************
  // Per-channel engines
  // ********************************************************************
  // Index 0 is luma, 1 is chroma; chroma uses stride 2 so each tap sees one component.
  logic [15:0]      blend_w;
  logic [15:0]      mot_w;
  logic [1:0]       noisy_w;
  logic [8:0]       absd_w [2];

  genvar ch;
  generate
    for (ch = 0; ch < rtnf_pkg::CHANNELS; ch++)
    begin : g_eng
      localparam int STRIDE = ch + 1;
      logic [7:0]          curve [rtnf_pkg::CURVE_BANKS * rtnf_pkg::CURVE_DEPTH];
      logic signed [8:0]   lb0 [rtnf_pkg::LINE_MAX];
      logic signed [8:0]   lb1 [rtnf_pkg::LINE_MAX];
      logic signed [10:0]  col_sr [rtnf_pkg::COL_SR_LEN];
      logic signed [8:0]   d;
      logic signed [10:0]  col;
      logic signed [13:0]  hsum;
      logic [13:0]         habs;
      logic [18:0]         avg;
      logic [6:0]          mot_next, mot_reg;
      logic signed [8:0]   dif_next, dif_reg;
      logic [7:0]          cur_next, cur_reg;
      logic [7:0]          coef;
      logic signed [16:0]  prod;
      logic signed [9:0]   sum;
      logic [7:0]          out_next;

      // Presets live only in the power-up image, so a software overwrite is permanent.
      initial
      begin
        for (int b = 0; b < rtnf_pkg::CURVE_BANKS; b++)
          for (int m = 0; m < rtnf_pkg::CURVE_DEPTH; m++)
            curve[b * rtnf_pkg::CURVE_DEPTH + m] = rtnf_pkg::rtnf_preset(b, m);
        for (int x = 0; x < rtnf_pkg::LINE_MAX; x++)
          {lb0[x], lb1[x], col_sr[x % 8]} = '0;
      end

      always_comb
      begin
        d    = $signed({1'b0, s1_cur_reg[ch*8 +: 8]}) - $signed({1'b0, s1_prv_reg[ch*8 +: 8]});
        col  = 11'(d) + 11'(lb0[s1_x_reg]) + 11'(lb1[s1_x_reg]);
        hsum = 14'(col) + 14'(col_sr[STRIDE - 1]) + 14'(col_sr[2*STRIDE - 1])
             + 14'(col_sr[3*STRIDE - 1]) + 14'(col_sr[4*STRIDE - 1]);
        habs = hsum[13] ? 14'(-hsum) : 14'(hsum);
        avg  = 19'(habs) * 19'(rtnf_pkg::FIR_SCALE);
        mot_next = (avg[18:rtnf_pkg::FIR_SHIFT] > 11'(rtnf_pkg::MOTION_MAX))
                 ? rtnf_pkg::MOTION_MAX : avg[rtnf_pkg::FIR_SHIFT +: 7];
        dif_next = -d;
        cur_next = s1_cur_reg[ch*8 +: 8];
        coef     = curve[{bank_use, mot_reg}];
        prod     = 17'(dif_reg) * $signed({9'h000, coef});
        sum      = $signed({2'b00, cur_reg}) + 10'(prod >>> rtnf_pkg::COEF_SHIFT);
        if (sum < 0)
          out_next = 8'h00;
        else if (sum > 10'sh0FF)
          out_next = 8'hFF;
        else
          out_next = sum[7:0];
      end

      always_ff @(posedge SYS_CLK)
      begin
        if (CURVE_WE && CURVE_CHAN == 1'(ch))
          curve[{CURVE_BANK, CURVE_ADDR}] <= CURVE_DATA;
        if (s1_v_reg)
        begin
          lb0[s1_x_reg] <= d;
          lb1[s1_x_reg] <= lb0[s1_x_reg];
          col_sr[0]     <= col;
          for (int i = 1; i < rtnf_pkg::COL_SR_LEN; i++)
            col_sr[i] <= col_sr[i - 1];
        end
        mot_reg <= mot_next;
        dif_reg <= dif_next;
        cur_reg <= cur_next;
      end

      assign blend_w[ch*8 +: 8] = out_next;
      assign mot_w[ch*8 +: 8]   = {1'b0, mot_reg};
      assign noisy_w[ch]        = (coef >= rtnf_pkg::NOISE_THRESH);
      assign absd_w[ch]         = dif_reg[8] ? 9'(-dif_reg) : 9'(dif_reg);
    end
  endgenerate

  // ********************************************************************
  // Statistics, events and output streams
  // ********************************************************************
  // Differences at or above the half-strength coefficient count as noise, the rest as motion.
  logic [31:0]      nacc_reg, nacc_next;
  logic [31:0]      macc_reg, macc_next;
  logic [31:0]      fnoise_next;
  logic [31:0]      fmot_next;
  logic [2:0]       live_next;
  logic [2:0]       stat_next;
  logic [31:0]      nadd;
  logic [31:0]      madd;

  always_comb
  begin
    nadd = (noisy_w[0] ? 32'(absd_w[0]) : 32'h0) + (noisy_w[1] ? 32'(absd_w[1]) : 32'h0);
    madd = (noisy_w[0] ? 32'h0 : 32'(absd_w[0])) + (noisy_w[1] ? 32'h0 : 32'(absd_w[1]));
    nacc_next   = nacc_reg;
    macc_next   = macc_reg;
    fnoise_next = FRAME_NOISE;
    fmot_next   = FRAME_MOTION;
    if (s2_v_reg)
    begin
      if (s2_s_reg)
      begin
        fnoise_next = nacc_reg;
        fmot_next   = macc_reg;
        nacc_next   = nadd;
        macc_next   = madd;
      end
      else
      begin
        nacc_next = nacc_reg + nadd;
        macc_next = macc_reg + madd;
      end
    end
    live_next = {under, sync_err, started};
    stat_next = (EVENT_STATUS & ~EVENT_CLEAR) | live_next;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      s2_v_reg        <= 1'b0;
      s2_s_reg        <= 1'b0;
      s2_e_reg        <= 1'b0;
      bank_reg        <= 4'(PRESET_BANK);
      nacc_reg        <= 32'h0000_0000;
      macc_reg        <= 32'h0000_0000;
      FRAME_NOISE     <= 32'h0000_0000;
      FRAME_MOTION    <= 32'h0000_0000;
      EVENT_LIVE      <= 3'h0;
      EVENT_STATUS    <= 3'h0;
      EVENT_IRQ       <= 1'b0;
      M_MEM_TDATA     <= 16'h0000;
      M_MEM_TVALID    <= 1'b0;
      M_MEM_TUSER     <= 1'b0;
      M_MEM_TLAST     <= 1'b0;
      M_OUT_TDATA     <= 16'h0000;
      M_OUT_TVALID    <= 1'b0;
      M_OUT_TUSER     <= 1'b0;
      M_OUT_TLAST     <= 1'b0;
      M_MOTION_TDATA  <= 16'h0000;
      M_MOTION_TVALID <= 1'b0;
      M_MOTION_TUSER  <= 1'b0;
      M_MOTION_TLAST  <= 1'b0;
    end
    else
    begin
      s2_v_reg        <= s1_v_reg;
      s2_s_reg        <= s1_s_reg;
      s2_e_reg        <= s1_e_reg;
      bank_reg        <= bank_next;
      nacc_reg        <= nacc_next;
      macc_reg        <= macc_next;
      FRAME_NOISE     <= fnoise_next;
      FRAME_MOTION    <= fmot_next;
      EVENT_LIVE      <= live_next;
      EVENT_STATUS    <= stat_next;
      EVENT_IRQ       <= |(stat_next & EVENT_ENABLE);
      M_MEM_TDATA     <= blend_w;
      M_MEM_TVALID    <= s2_v_reg;
      M_MEM_TUSER     <= s2_s_reg;
      M_MEM_TLAST     <= s2_e_reg;
      M_OUT_TDATA     <= blend_w;
      M_OUT_TVALID    <= s2_v_reg;
      M_OUT_TUSER     <= s2_s_reg;
      M_OUT_TLAST     <= s2_e_reg;
      M_MOTION_TDATA  <= mot_w;
      M_MOTION_TVALID <= s2_v_reg;
      M_MOTION_TUSER  <= s2_s_reg;
      M_MOTION_TLAST  <= s2_e_reg;
    end
  end

endmodule : rtnf_filter

`default_nettype wire

// *** rtnf_checker.sv ***
// Port-level checker for the recursive temporal noise filter.
// Assumes one clock domain and the three-edge stream latency of the filter.
`timescale 1ns/1ps
`default_nettype none
module rtnf_checker (
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST,
  // Current-frame input
  input wire logic        S_CURR_TVALID,
  input wire logic        S_CURR_TUSER,
  input wire logic        S_CURR_TLAST,
  input wire logic        S_CURR_TREADY,
  // Output streams
  input wire logic [15:0] M_MEM_TDATA,
  input wire logic        M_MEM_TVALID,
  input wire logic        M_MEM_TUSER,
  input wire logic        M_MEM_TLAST,
  input wire logic [15:0] M_OUT_TDATA,
  input wire logic        M_OUT_TVALID,
  input wire logic [15:0] M_MOTION_TDATA,
  input wire logic        M_MOTION_TVALID,
  // Events
  input wire logic [2:0]  EVENT_LIVE,
  input wire logic [2:0]  EVENT_STATUS,
  input wire logic [2:0]  EVENT_CLEAR,
  input wire logic [2:0]  EVENT_ENABLE,
  input wire logic        EVENT_IRQ
);
  // ************************************
  // Assertions
  // ************************************
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence curr_sof_s;
    S_CURR_TVALID && S_CURR_TUSER;
  endsequence
  sequence beat_out_s;
    M_MEM_TVALID && M_OUT_TVALID && M_MOTION_TVALID;
  endsequence
  curr_ready_a: assert property (!$past(RST) |-> S_CURR_TREADY)
    else $error("current ready dropped");
  beat_latency_a: assert property (S_CURR_TVALID |-> ##3 beat_out_s)
    else $error("output beat missing");
  sof_carry_a: assert property (curr_sof_s |-> ##3 M_MEM_TUSER)
    else $error("start of frame lost");
  line_end_a: assert property (S_CURR_TVALID && S_CURR_TLAST |-> ##3 M_MEM_TLAST)
    else $error("line end lost");
  copy_match_a: assert property (M_MEM_TVALID |-> M_OUT_TDATA == M_MEM_TDATA)
    else $error("duplicate stream differs");
  motion_align_a: assert property (M_MOTION_TVALID == M_MEM_TVALID)
    else $error("motion stream out of step");
  motion_range_a: assert property (M_MOTION_TVALID |-> !M_MOTION_TDATA[7] && !M_MOTION_TDATA[15])
    else $error("motion above 127");
  frame_event_a: assert property (EVENT_LIVE[0] |-> $past(S_CURR_TVALID && S_CURR_TUSER))
    else $error("frame event without start of frame");
  status_set_a: assert property (EVENT_LIVE[0] |-> ##[0:1] EVENT_STATUS[0])
    else $error("status not set by event");
  status_hold_a: assert property (EVENT_STATUS[0] && !EVENT_CLEAR[0] |=> EVENT_STATUS[0])
    else $error("status dropped without clear");
  irq_mask_a: assert property (1'b1 |=> EVENT_IRQ == |(EVENT_STATUS & $past(EVENT_ENABLE)))
    else $error("irq does not follow enabled status");
endmodule : rtnf_checker
bind rtnf_filter rtnf_checker chk (.SYS_CLK(SYS_CLK), .RST(RST), .S_CURR_TVALID(S_CURR_TVALID),
  .S_CURR_TUSER(S_CURR_TUSER), .S_CURR_TLAST(S_CURR_TLAST), .S_CURR_TREADY(S_CURR_TREADY),
  .M_MEM_TDATA(M_MEM_TDATA), .M_MEM_TVALID(M_MEM_TVALID), .M_MEM_TUSER(M_MEM_TUSER), .M_MEM_TLAST(M_MEM_TLAST),
  .M_OUT_TDATA(M_OUT_TDATA), .M_OUT_TVALID(M_OUT_TVALID), .M_MOTION_TDATA(M_MOTION_TDATA),
  .M_MOTION_TVALID(M_MOTION_TVALID), .EVENT_LIVE(EVENT_LIVE), .EVENT_STATUS(EVENT_STATUS),
  .EVENT_CLEAR(EVENT_CLEAR), .EVENT_ENABLE(EVENT_ENABLE), .EVENT_IRQ(EVENT_IRQ));
`default_nettype wire

// *** rtnf_source.sv ***
// Previous-frame source: a frame-buffer read engine that honours back-pressure.
// Assumes start pulses for one cycle; skip junk beats without start-of-frame precede the frame.
`timescale 1ns/1ps
`default_nettype none
module rtnf_source #(
  parameter int WIDTH = 8,
  parameter int FRAME = 24
) (
  // Clock and control
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [3:0]  skip,
  input  wire logic [7:0]  offset,
  // Stream master
  output logic [15:0]      tdata,
  output logic             tvalid,
  output logic             tuser,
  output logic             tlast,
  input  wire logic        tready
);
  int          idx_reg  = FRAME;
  logic [15:0] last_reg = 16'h0000;
  // ************************************
  // Beat sequencing
  // ************************************
  always @(posedge clk)
  begin
    if (rst)
      idx_reg <= FRAME;
    else if (start)
      idx_reg <= -int'(skip);
    else if (tvalid && tready)
    begin
      last_reg <= tdata;
      idx_reg  <= idx_reg + 1;
    end
  end
  // A stalled beat is held whole; an idle bus shows the inverse so stale data cannot pass.
  assign tvalid = idx_reg < FRAME;
  assign tdata  = !tvalid ? ~last_reg : idx_reg < 0 ? 16'hA5A5 :
                  {8'(8'h40 + idx_reg + offset), 8'(8'h10 + idx_reg + offset)};
  assign tuser  = tvalid && idx_reg == 0;
  assign tlast  = tvalid && idx_reg >= 0 && idx_reg % WIDTH == WIDTH - 1;
endmodule : rtnf_source
`default_nettype wire

// *** test_recursive_temporal_noise_filter.sv ***
// Self-checking bench for the recursive temporal noise filter.
// Assumes the checker is bound in and the previous frame comes from rtnf_source.
`timescale 1ns/1ps
`default_nettype none
module test_recursive_temporal_noise_filter;
  localparam int W  = 8;
  localparam int FR = 24;
  typedef struct {int bank, mid, off, skip, add, noise, mot;} rtnf_row_s;
  logic        SYS_CLK = 1'b0;
  logic        RST = 1'b1;
  logic [15:0] cur_d = 16'h0000, prev_d, mem_d, out_d, mot_d;
  logic        cur_v = 1'b0, cur_u = 1'b0, cur_l = 1'b0, cur_r, prev_v, prev_u, prev_l, prev_r;
  logic        mem_v, mem_u, mem_l, out_v, out_u, out_l, mot_v, mot_u, mot_l, irq;
  logic [3:0]  bank_sel = 4'h0, cbank = 4'h0, p_skip = 4'h0;
  logic        cwe = 1'b0, cchan = 1'b0, p_start = 1'b0;
  logic [6:0]  caddr = 7'h00;
  logic [7:0]  cdata = 8'h00, p_off = 8'h00;
  logic [31:0] noise, motion;
  logic [2:0]  ev_live, ev_stat, ev_clr = 3'h0, ev_en = 3'h0;
  logic [15:0] exp_q[$];
  int          err_total = 0, checks = 0, out_n = 0, cyc = 0;
  // Bank 9 adds one step of recursion for a difference of two; bank 8 is all zero.
  rtnf_row_s   rows[6] = '{'{0, 0, 0, 3, 0, 0, 0}, '{0, 0, 0, 0, 0, 0, 0}, '{8, 8, 2, 0, 0, 0, 0},
                           '{9, 9, 2, 0, 1, 0, 0}, '{9, 8, 2, 0, 1, 0, 96}, '{8, 8, 2, 0, 0, 96, 0}};
  always #5 SYS_CLK = ~SYS_CLK;
  rtnf_filter dut (.SYS_CLK(SYS_CLK), .RST(RST), .S_CURR_TDATA(cur_d), .S_CURR_TVALID(cur_v),
    .S_CURR_TUSER(cur_u), .S_CURR_TLAST(cur_l), .S_CURR_TREADY(cur_r), .S_PREV_TDATA(prev_d),
    .S_PREV_TVALID(prev_v), .S_PREV_TUSER(prev_u), .S_PREV_TLAST(prev_l), .S_PREV_TREADY(prev_r),
    .M_MEM_TDATA(mem_d), .M_MEM_TVALID(mem_v), .M_MEM_TUSER(mem_u), .M_MEM_TLAST(mem_l), .M_OUT_TDATA(out_d),
    .M_OUT_TVALID(out_v), .M_OUT_TUSER(out_u), .M_OUT_TLAST(out_l), .M_MOTION_TDATA(mot_d),
    .M_MOTION_TVALID(mot_v), .M_MOTION_TUSER(mot_u), .M_MOTION_TLAST(mot_l), .BANK_SEL(bank_sel),
    .CURVE_WE(cwe), .CURVE_CHAN(cchan), .CURVE_BANK(cbank), .CURVE_ADDR(caddr), .CURVE_DATA(cdata),
    .FRAME_NOISE(noise), .FRAME_MOTION(motion), .EVENT_LIVE(ev_live), .EVENT_STATUS(ev_stat),
    .EVENT_CLEAR(ev_clr), .EVENT_ENABLE(ev_en), .EVENT_IRQ(irq));
  rtnf_source #(.WIDTH(W), .FRAME(FR)) prev_src (.clk(SYS_CLK), .rst(RST), .start(p_start), .skip(p_skip),
    .offset(p_off), .tdata(prev_d), .tvalid(prev_v), .tuser(prev_u), .tlast(prev_l), .tready(prev_r));
  // ************************************
  // Checking and reporting
  // ************************************
  function automatic logic [15:0] pix(input int i, input int a);
    return {8'(8'h40 + i + a), 8'(8'h10 + i + a)};
  endfunction : pix
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    checks++;
    if (seen !== expv)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  always @(posedge SYS_CLK)
  begin
    cyc <= cyc + 1;
    if (mem_v)
    begin
      check("mem data", mem_d, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
      check("mem sof", {mem_u, out_u, mot_u}, {3{out_n % FR == 0}});
      check("mem line end", {mem_l, out_l, mot_l}, {3{out_n % W == W - 1}});
      check("copy data", out_d, mem_d);
      out_n <= out_n + 1;
    end
    if (cyc == 2000)
    begin
      check("timeout", cyc, 0);
      stop_test();
    end
  end
  // ************************************
  // Frame driver
  // ************************************
  task automatic run_row(input rtnf_row_s r, input int n);
    @(negedge SYS_CLK);
    check("frame noise", noise, r.noise);
    check("frame motion", motion, r.mot);
    @(posedge SYS_CLK);
    bank_sel <= 4'(r.bank);
    p_skip   <= 4'(r.skip);
    p_off    <= 8'(r.off);
    p_start  <= 1'b1;
    @(posedge SYS_CLK);
    p_start <= 1'b0;
    repeat (r.skip + 4) @(posedge SYS_CLK);
    for (int i = 0; i < FR; i++)
    begin
      cur_v <= 1'b1;
      cur_d <= pix(i, 0);
      cur_u <= i == 0;
      cur_l <= i % W == W - 1;
      if (i == 5)
        bank_sel <= 4'(r.mid);
      exp_q.push_back(pix(i, r.add));
      @(posedge SYS_CLK);
    end
    {cur_v, cur_u, cur_l} <= 3'h0;
    cur_d <= ~cur_d;
    repeat (12) @(posedge SYS_CLK);
    $display("Row %0d done", n);
  endtask : run_row
  initial
  begin
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    for (int a = 0; a < 256; a++)
    begin
      {cwe, cchan, cbank, caddr} <= {1'b1, a[7], 4'h9, a[6:0]};
      cdata <= 8'(2 * (127 - a % 128));
      @(posedge SYS_CLK);
    end
    cwe <= 1'b0;
    foreach (rows[r])
      run_row(rows[r], r);
    @(negedge SYS_CLK);
    check("status", ev_stat[0], 1'b1);
    @(posedge SYS_CLK);
    ev_en <= 3'h1;
    repeat (2) @(posedge SYS_CLK);
    ev_clr <= 3'h1;
    check("irq", irq, 1'b1);
    @(posedge SYS_CLK);
    ev_clr <= 3'h0;
    @(negedge SYS_CLK);
    check("cleared", {irq, ev_stat[0]}, 2'b00);
    $display("Event test done");
    @(posedge SYS_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    check("reset outputs", {cur_r, prev_r, mem_v}, 3'b000);
    run_row(rows[0], 6);
    check("all beats out", exp_q.size(), 0);
    stop_test();
  end
endmodule : test_recursive_temporal_noise_filter
`default_nettype wire
